// *** include/flash_host_defines.svh ***
// Timing counts and field constants for the parallel flash host controller
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH
// Clock period in ns (200 MHz)
`define CLK_PERIOD_NS 5
// Read access time in ns, rounded up to cycles
`define T_ACC_NS 70
`define T_ACC_CYC ((`T_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Write strobe low time in ns, rounded up to cycles
`define T_WP_NS 35
`define T_WP_CYC ((`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Recovery between cycles in ns
`define T_REC_NS 20
`define T_REC_CYC ((`T_REC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Hardware reset pulse width in ns
`define T_RP_NS 500
`define T_RP_CYC ((`T_RP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Wait after reset release before first access, ns
`define T_RH_NS 50
`define T_RH_CYC ((`T_RH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Pin widths and phase timer width
`define ADDR_W 19
`define DATA_W 16
`define CNT_W 8
// Program write counts, normal and fast shortcut
`define WR_NORMAL 3'h4
`define WR_FAST 3'h2
// Top data pin index, doubles as low address bit in byte mode
`define TOP_DQ 15
`endif

// *** include/flash_host_pkg.sv ***
// Types for the parallel flash host controller
package flash_host_pkg;
  // Bus sequencer states
  typedef enum logic [2:0] {
    ST_RST = 3'b000,
    ST_RH = 3'b001,
    ST_IDLE = 3'b010,
    ST_RD = 3'b011,
    ST_WR = 3'b100,
    ST_REC = 3'b101
  } bus_state_t;
endpackage

// *** core/seq_word_rom.sv ***
// Small command-sequence memory: address/data pairs for unlock cycles
`timescale 1ns/10ps
`default_nettype none
module seq_word_rom (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] idx_i,
  output logic [26:0] word_o
);
  // Entries 0..2: normal program prefix; shortcut prefix reuses entry 2 alone
  logic [26:0] rom [0:7]; // Constant table, 11-bit address + 16-bit data
  always_comb begin
    rom[0] = {11'h555, 16'h00AA};
    rom[1] = {11'h2AA, 16'h0055};
    rom[2] = {11'h555, 16'h00A0};
    rom[3] = 27'h0;
    rom[4] = 27'h0;
    rom[5] = 27'h0;
    rom[6] = 27'h0;
    rom[7] = 27'h0;
  end
  // Registered read data keeps the pin path short
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_o <= 27'h0;
    end else begin
      word_o <= rom[idx_i];
    end
  end
endmodule
`default_nettype wire

// *** core/flash_host.sv ***
// Host-side bus controller driving an asynchronous parallel NOR flash
//
// Contract
// - Read: select and gate low, strobe high
// - Write: strobe and select low, gate high
// - Address nineteen bits word, twenty byte
// - Shortcut program needs two writes, else four
`timescale 1ns/10ps
`include "flash_host_defines.svh"
`default_nettype none
module flash_host (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic REQ_I,
  input wire logic REQ_WR_I,
  input wire logic REQ_PROG_I,
  input wire logic FAST_I,
  input wire logic BYTE_MODE_I,
  input wire logic [19:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic DEV_RESET_I,
  output logic BUSY_O,
  output logic DONE_O,
  output logic [15:0] RDATA_O,
  output logic READY_O,
  output logic [18:0] ADDR_O,
  output logic [15:0] DQ_O,
  output logic [15:0] DQ_OE_O,
  input wire logic [15:0] DQ_I,
  output logic CS_N_O,
  output logic OG_N_O,
  output logic WS_N_O,
  output logic HW_RESET_N_O,
  output logic WIDTH_SEL_N_O,
  input wire logic READY_BUSY_N_I
);
  flash_host_pkg::bus_state_t state_r; // Sequencer state
  logic [`CNT_W-1:0] cnt_r; // Phase timer
  logic [2:0] wr_left_r; // Write cycles still to issue in a program
  logic [2:0] seq_idx_r; // Index into unlock prefix table
  logic cur_wr_r; // Current cycle is a write
  logic [26:0] seq_word; // Prefix address/data from the table
  logic [15:0] dq_s1_r, dq_s2_r; // Data pin synchroniser
  logic rb_s1_r, rb_s2_r; // Ready/busy synchroniser
  logic prefix; // Current write comes from the table
  logic [19:0] eff_addr; // Address of current cycle, 20 bits; byte address in byte mode, word address in word mode
  logic [15:0] eff_data; // Data of current cycle

  seq_word_rom u_rom (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .idx_i(seq_idx_r),
    .word_o(seq_word)
  );

  // Prefix cycles exist only while more writes remain than the last one
  assign prefix = cur_wr_r && (wr_left_r > 3'h1);
  // Table addresses are word addresses; byte mode doubles them
  assign eff_addr = prefix ? (BYTE_MODE_I ? {8'h0, seq_word[26:16], 1'b0}
                                          : {9'h0, seq_word[26:16]})
                           : ADDR_I;
  assign eff_data = prefix ? seq_word[15:0] : WDATA_I;

  // Two-stage sync of pins from the device's domain
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dq_s1_r <= 16'h0;
      dq_s2_r <= 16'h0;
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
    end else begin
      dq_s1_r <= DQ_I;
      dq_s2_r <= dq_s1_r;
      rb_s1_r <= READY_BUSY_N_I;
      rb_s2_r <= rb_s1_r;
    end
  end

  // Sequencer and phase timer
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r <= flash_host_pkg::ST_RST;
      cnt_r <= 8'h0;
      wr_left_r <= 3'h0;
      seq_idx_r <= 3'h0;
      cur_wr_r <= 1'b0;
    end else begin
      case (state_r)
        flash_host_pkg::ST_RST: begin
          // Hold device reset for its minimum pulse
          if (cnt_r >= 8'(`T_RP_CYC - 1)) begin
            state_r <= flash_host_pkg::ST_RH;
            cnt_r <= 8'h0;
          end else begin
            cnt_r <= cnt_r + 8'h1;
          end
        end
        flash_host_pkg::ST_RH: begin
          // Device is back in array read; plain reads follow
          if (cnt_r >= 8'(`T_RH_CYC - 1)) begin
            state_r <= flash_host_pkg::ST_IDLE;
            cnt_r <= 8'h0;
          end else begin
            cnt_r <= cnt_r + 8'h1;
          end
        end
        flash_host_pkg::ST_IDLE: begin
          cnt_r <= 8'h0;
          seq_idx_r <= 3'h0;
          if (DEV_RESET_I) begin
            state_r <= flash_host_pkg::ST_RST;
          end else if (REQ_I && REQ_WR_I) begin
            // Program takes four writes, or two under shortcut
            wr_left_r <= REQ_PROG_I ? (FAST_I ? `WR_FAST : `WR_NORMAL)
                                    : 3'h1;
            seq_idx_r <= (REQ_PROG_I && FAST_I) ? 3'h2 : 3'h0;
            cur_wr_r <= 1'b1;
            state_r <= flash_host_pkg::ST_WR;
          end else if (REQ_I) begin
            wr_left_r <= 3'h0;
            cur_wr_r <= 1'b0;
            state_r <= flash_host_pkg::ST_RD;
          end
        end
        flash_host_pkg::ST_RD: begin
          // Wait out access time before sampling data
          if (cnt_r >= 8'(`T_ACC_CYC + 1)) begin
            state_r <= flash_host_pkg::ST_REC;
            cnt_r <= 8'h0;
          end else begin
            cnt_r <= cnt_r + 8'h1;
          end
        end
        flash_host_pkg::ST_WR: begin
          if (cnt_r >= 8'(`T_WP_CYC - 1)) begin
            state_r <= flash_host_pkg::ST_REC;
            cnt_r <= 8'h0;
            wr_left_r <= wr_left_r - 3'h1;
            seq_idx_r <= seq_idx_r + 3'h1;
          end else begin
            cnt_r <= cnt_r + 8'h1;
          end
        end
        flash_host_pkg::ST_REC: begin
          // Bus quiet between cycles
          if (cnt_r >= 8'(`T_REC_CYC - 1)) begin
            cnt_r <= 8'h0;
            state_r <= (cur_wr_r && wr_left_r != 3'h0)
                       ? flash_host_pkg::ST_WR : flash_host_pkg::ST_IDLE;
          end else begin
            cnt_r <= cnt_r + 8'h1;
          end
        end
        default: begin
          state_r <= flash_host_pkg::ST_RST;
        end
      endcase
    end
  end

  // Control pins; device is only selected inside a cycle
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CS_N_O <= 1'b1;
      OG_N_O <= 1'b1;
      WS_N_O <= 1'b1;
      HW_RESET_N_O <= 1'b0;
    end else begin
      HW_RESET_N_O <= (state_r != flash_host_pkg::ST_RST);
      CS_N_O <= !(state_r == flash_host_pkg::ST_RD ||
                  state_r == flash_host_pkg::ST_WR);
      // Read: gate low, strobe high
      OG_N_O <= (state_r != flash_host_pkg::ST_RD);
      // Write: strobe low, gate high
      WS_N_O <= (state_r != flash_host_pkg::ST_WR);
    end
  end

  // Address, width select and data drive
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ADDR_O <= 19'h0;
      DQ_O <= 16'h0;
      DQ_OE_O <= 16'h0;
      WIDTH_SEL_N_O <= 1'b1;
    end else begin
      // Width select high = word, low = byte
      WIDTH_SEL_N_O <= !BYTE_MODE_I;
      // Byte mode drops bit 0 onto top data pin
      ADDR_O <= BYTE_MODE_I ? eff_addr[19:1] : eff_addr[18:0];
      if (state_r == flash_host_pkg::ST_WR) begin
        // Bytes or words of program data per width
        DQ_O <= BYTE_MODE_I ? {eff_addr[0], 7'h0, eff_data[7:0]}
                            : eff_data;
        DQ_OE_O <= BYTE_MODE_I ? 16'h80FF : 16'hFFFF;
      end else if (BYTE_MODE_I && state_r == flash_host_pkg::ST_RD) begin
        // Top pin still carries low address while reading
        DQ_O <= {eff_addr[0], 15'h0};
        DQ_OE_O <= 16'h8000;
      end else begin
        // Otherwise release bus so device can drive it
        DQ_O <= 16'h0;
        DQ_OE_O <= 16'h0;
      end
    end
  end

  // Answer to the user port
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 16'h0;
      DONE_O <= 1'b0;
      BUSY_O <= 1'b1;
      READY_O <= 1'b0;
    end else begin
      READY_O <= rb_s2_r;
      BUSY_O <= (state_r != flash_host_pkg::ST_IDLE) || REQ_I;
      DONE_O <= 1'b0;
      if (state_r == flash_host_pkg::ST_RD && cnt_r == 8'(`T_ACC_CYC + 1))
      begin
        // Array, identifier or status; byte mode keeps low byte
        RDATA_O <= BYTE_MODE_I ? {8'h0, dq_s2_r[7:0]} : dq_s2_r;
        DONE_O <= 1'b1;
      end else if (state_r == flash_host_pkg::ST_REC && cur_wr_r &&
                   wr_left_r == 3'h0 && cnt_r == 8'(`T_REC_CYC - 1)) begin
        DONE_O <= 1'b1; // Command latch gets writes only
      end
    end
  end

  // Read and write never overlap at the pins
  a_rd_wr_excl: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !(!OG_N_O && !WS_N_O)) else $error("gate and strobe both low");
  a_rd_select: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !OG_N_O |-> !CS_N_O && WS_N_O) else $error("bad read levels");
  a_wr_float: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !WS_N_O |-> OG_N_O && !CS_N_O) else $error("bad write levels");
  a_rst_quiet: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !HW_RESET_N_O |-> CS_N_O && DQ_OE_O == 16'h0)
    else $error("bus active in reset");
  a_byte_hiz: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !WIDTH_SEL_N_O |-> DQ_OE_O[14:8] == 7'h0)
    else $error("upper byte driven");
  a_read_release: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !OG_N_O |-> DQ_OE_O[7:0] == 8'h0) else $error("contention");
  a_rst_width: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    $fell(HW_RESET_N_O) |-> !HW_RESET_N_O [*8])
    else $error("reset too short");
  a_desel_float: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    CS_N_O |-> DQ_OE_O == 16'h0) else $error("driven idle");
  c_read: cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    $fell(OG_N_O));
  c_write: cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    $fell(WS_N_O));
  c_byte_wr: cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !WIDTH_SEL_N_O && !WS_N_O);
endmodule
`default_nettype wire

// *** sim/flash_dev_model.sv ***
// Behavioural flash device model seen by the host controller
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model #(parameter logic [7:0] ID = 8'h5A) ( // Arbitrary code
  input wire logic clk_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic reset_n_i,
  input wire logic byte_n_i,
  input wire logic [18:0] addr_i,
  input wire logic [15:0] host_q_i,
  input wire logic [15:0] host_oe_i,
  output logic [15:0] line_o,
  output logic ready_busy_n_o,
  output logic clash_o = 1'b0
);
  logic [15:0] mem [int]; // Written words
  bit ers [int]; // Erased sectors; earlier writes there are kept
  int st, busy;
  bit idm, byp, era, wr_on;
  logic [18:0] la;
  logic [15:0] ld, rd, w, last, flt = 16'h00FF;
  wire on = !ce_n_i && !oe_n_i && reset_n_i;
  // Access delay; stale data before it. Ten whole cycles, so the data changes
  // on a clock edge, at least two cycles before the edge whose sample the host keeps.
  wire [15:0] #50 rd_d = rd;
  assign ready_busy_n_o = busy == 0;
  function automatic logic [15:0] word_at(logic [18:0] a);
    if (mem.exists(a)) return mem[a];
    return ers.exists(a[18:15]) ? 16'hFFFF : a[15:0] ^ 16'hA5C3;
  endfunction
  // Undriven pins wander, so a stale value never passes
  always @* for (int i = 0; i < 16; i++)
    line_o[i] = host_oe_i[i] ? host_q_i[i] :
      on && (byte_n_i || i < 8) ? rd_d[i] : flt[i];
  // Writes commit when the strobe rises, from what the low phase held
  always @(posedge clk_i) begin
    flt <= ~flt;
    w = word_at(addr_i);
    rd <= busy > 0 ? {8'h00, ~last[7], 7'h00} :
      idm ? {8'h00, ID} : byte_n_i ? w :
      {8'h00, line_o[15] ? w[15:8] : w[7:0]};
    if (on && (!we_n_i || |host_oe_i[14:0] || host_oe_i[15] == byte_n_i))
      clash_o <= 1'b1;
    if (!reset_n_i)
      {st, busy, idm, byp, era, wr_on} = '0;
    else if (!we_n_i && !ce_n_i) begin
      wr_on = 1;
      la = addr_i;
      ld = line_o;
      if (!oe_n_i) clash_o <= 1'b1;
    end else if (wr_on && busy == 0) begin
      wr_on = 0;
      cmd(la[10:0] == 11'h555, la[10:0] == 11'h2AA, ld[7:0]);
    end else wr_on = 0;
    if (busy > 0) busy--;
  end
  // Command latch sequencing
  task automatic cmd(bit u, bit v, logic [7:0] d);
    if (d == 8'hF0 && st != 3) {st, idm} = '0;
    else case (st)
      0: st = u && d == 8'hAA ? 1 : byp && d == 8'hA0 ? 3 : 0;
      1: st = v && d == 8'h55 ? 2 : 0;
      2: begin
        idm = d == 8'h90;
        byp |= d == 8'h20;
        if (era && d == 8'h30) ers[la[18:15]] = 1;
        if (era && d == 8'h30) busy = 60;
        era = d == 8'h80;
        st = d == 8'hA0 ? 3 : 0;
      end
      default: begin
        w = word_at(la);
        mem[la] = w & (byte_n_i ? ld : ld[15] ? {ld[7:0], 8'hFF} :
          {8'hFF, ld[7:0]});
        last = ld;
        busy = 60;
        st = 0;
      end
    endcase
  endtask
endmodule
`default_nettype wire

// *** sim/tb_flash_host.sv ***
// Self-checking bench: host controller against a device model
`timescale 1ns/10ps
`default_nettype none
module tb_flash_host;
  typedef struct {logic [15:0] v; logic [15:0] m;} exp_t;
  localparam logic [7:0] ID = 8'h5A; // Arbitrary code
  logic clk = 0, rst_n = 0, req = 0, wr = 0, prog = 0, fast = 0;
  logic bmode = 0, dreset = 0;
  logic [19:0] addr = '0, a;
  logic [15:0] wdata = '0, d, w, rdata, dq_o, dq_oe, line;
  logic busy, done, ready, cs_n, og_n, ws_n, hrst_n, wsel_n, rb_n, clash;
  logic [18:0] fa;
  exp_t q[$], e;
  int err_count = 0, checked = 0, cyc = 0;
  flash_host flash_host_inst (.REF_CLK_I(clk), .RST_N_I(rst_n), .REQ_I(req),
    .REQ_WR_I(wr), .REQ_PROG_I(prog), .FAST_I(fast), .BYTE_MODE_I(bmode),
    .ADDR_I(addr), .WDATA_I(wdata), .DEV_RESET_I(dreset), .BUSY_O(busy),
    .DONE_O(done), .RDATA_O(rdata), .READY_O(ready), .ADDR_O(fa),
    .DQ_O(dq_o), .DQ_OE_O(dq_oe), .DQ_I(line), .CS_N_O(cs_n),
    .OG_N_O(og_n), .WS_N_O(ws_n), .HW_RESET_N_O(hrst_n),
    .WIDTH_SEL_N_O(wsel_n), .READY_BUSY_N_I(rb_n));
  flash_dev_model #(.ID(ID)) flash_dev_model_inst (.clk_i(clk),
    .ce_n_i(cs_n), .oe_n_i(og_n), .we_n_i(ws_n), .reset_n_i(hrst_n),
    .byte_n_i(wsel_n), .addr_i(fa), .host_q_i(dq_o), .host_oe_i(dq_oe),
    .line_o(line), .ready_busy_n_o(rb_n), .clash_o(clash));
  initial forever #2.5 clk = ~clk;
  task automatic cmp(string s, logic [15:0] x, logic [15:0] g);
    checked++;
    if (g !== x) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", s, x, g);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      report_and_stop();
    end
  end
  // Each completion retires the oldest note; writes carry an empty mask
  always @(negedge clk) if (done === 1'b1) begin
    if (q.size() == 0) cmp("completion count", 16'h0, 16'h1);
    else begin
      e = q.pop_front();
      cmp("read data", e.v & e.m, rdata & e.m);
    end
  end
  // Request held until completion, dropped in the completion cycle
  task automatic op(bit w_, bit p, bit f, logic [19:0] ad,
    logic [15:0] dt, exp_t x);
    @(negedge clk);
    {req, wr, prog, fast, addr, wdata} = {1'b1, w_, p, f, ad, dt};
    q.push_back(x);
    do @(negedge clk); while (done !== 1'b1);
    req = 0;
  endtask
  task automatic rd(logic [19:0] ad, logic [15:0] v, logic [15:0] m);
    op(0, 0, 0, ad, 16'h0, '{v, m});
  endtask
  task automatic wr_cmd(logic [19:0] ad, logic [7:0] dt);
    op(1, 0, 0, ad, {8'h00, dt}, '{16'h0, 16'h0});
  endtask
  // Word mode passes the address through as a word address, so the
  // unlock cycles use word addresses here
  task automatic unlock(logic [7:0] c);
    wr_cmd(20'h555, 8'hAA);
    wr_cmd(20'h2AA, 8'h55);
    wr_cmd(20'h555, c);
  endtask
  // Status read while busy, followed by a wait for the ready/busy pin
  task automatic status();
    rd(a, {8'h00, ~d[7], 7'h00}, 16'h0080);
    while (ready !== 1'b1) @(negedge clk);
  endtask
  initial begin
    a = 20'($urandom(57248));
    repeat (4) @(negedge clk);
    cmp("device reset pin", 16'h0, {15'h0, hrst_n});
    rst_n = 1;
    while (busy !== 1'b0) @(negedge clk);
    for (int i = 0; i < 4; i++) begin
      // Nineteen-bit word address in word mode
      a = 20'($urandom) & 20'h7FFFF;
      rd(a, a[15:0] ^ 16'hA5C3, 16'hFFFF);
    end
    d = 16'($urandom);
    op(1, 1, 0, a, d, '{16'h0, 16'h0});
    status();
    rd(a, (a[15:0] ^ 16'hA5C3) & d, 16'hFFFF);
    rd(20'h555, 16'h0555 ^ 16'hA5C3, 16'hFFFF);
    bmode = 1;
    a = 20'($urandom) | 20'h1;
    d = 16'($urandom);
    op(1, 1, 0, a, d, '{16'h0, 16'h0});
    status();
    cmp("width select", 16'h0, {15'h0, wsel_n});
    w = a[16:1] ^ 16'hA5C3;
    rd(a, {8'h00, w[15:8] & d[7:0]}, 16'h00FF);
    rd(a ^ 20'h1, {8'h00, w[7:0]}, 16'h00FF);
    bmode = 0;
    unlock(8'h20);
    a = 20'($urandom) & 20'h7FFFF;
    d = 16'($urandom);
    op(1, 1, 1, a, d, '{16'h0, 16'h0});
    status();
    rd(a, (a[15:0] ^ 16'hA5C3) & d, 16'hFFFF);
    unlock(8'h90);
    rd(20'h0, {8'h00, ID}, 16'h00FF);
    while (busy !== 1'b0) @(negedge clk);
    dreset = 1;
    @(negedge clk);
    dreset = 0;
    while (hrst_n !== 1'b0) @(negedge clk);
    while (busy !== 1'b0) @(negedge clk);
    rd(20'h0, 16'hA5C3, 16'hFFFF);
    unlock(8'h80);
    wr_cmd(20'h555, 8'hAA);
    wr_cmd(20'h2AA, 8'h55);
    wr_cmd(a, 8'h30);
    status();
    rd(a ^ 20'h4, 16'hFFFF, 16'hFFFF);
    // Top word-address bit picks a sector outside the erased one
    rd(a ^ 20'h40000, a[15:0] ^ 16'hA5C3, 16'hFFFF);
    cmp("bus clash", 16'h0, {15'h0, clash});
    report_and_stop();
  end
endmodule
`default_nettype wire
